/* File: rtl/ucsc_pkg.sv */
`default_nettype none

package ucsc_pkg;

    // ----------------------------------------------------------------
    // Register map: word index, byte address is four times the index.
    // ----------------------------------------------------------------
    localparam int unsigned APB_AW = 8;
    localparam logic [2:0] IDX_BAUD_HI = 3'h0;
    localparam logic [2:0] IDX_BAUD_LO = 3'h1;
    localparam logic [2:0] IDX_FRAME = 3'h2;
    localparam logic [2:0] IDX_CTL_MAIN = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;
    localparam logic [2:0] IDX_EXT = 3'h5;
    localparam logic [2:0] IDX_CTL3 = 3'h6;
    localparam logic [2:0] IDX_DATA = 3'h7;

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int unsigned BH_TWO_STOP = 5;
    localparam int unsigned FC_LOOP = 7;
    localparam int unsigned FC_SINGLE = 5;
    localparam int unsigned FC_NINE = 4;
    localparam int unsigned FC_WAKE = 3;
    localparam int unsigned FC_ILT = 2;
    localparam int unsigned FC_PE = 1;
    localparam int unsigned FC_ODD = 0;
    localparam int unsigned CM_TX_EMPTY_IE = 7;
    localparam int unsigned CM_TX_DONE_IE = 6;
    localparam int unsigned CM_RX_FULL_IE = 5;
    localparam int unsigned CM_IDLE_IE = 4;
    localparam int unsigned CM_TE = 3;
    localparam int unsigned CM_RE = 2;
    localparam int unsigned CM_STANDBY = 1;
    localparam int unsigned CM_BREAK = 0;
    localparam int unsigned SF_TX_BUFFER_EMPTY = 7;
    localparam int unsigned SF_TC = 6;
    localparam int unsigned SF_RX_BUFFER_FULL = 5;
    localparam int unsigned SF_IDLE = 4;
    localparam int unsigned SF_OVR = 3;
    localparam int unsigned SF_NF = 2;
    localparam int unsigned SF_FE = 1;
    localparam int unsigned SF_PF = 0;
    localparam int unsigned EX_LONG_BREAK = 2;
    localparam int unsigned C3_R8 = 7;
    localparam int unsigned C3_T8 = 6;
    localparam int unsigned C3_WIRE_DIR = 5;

    // ----------------------------------------------------------------
    // Reset values and timing counts.
    // ----------------------------------------------------------------
    localparam logic [7:0] CTL_MAIN_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'hc0;
    localparam logic [12:0] DIV_RST = 13'h0004;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] START_FIRST = 4'h3;
    localparam logic [3:0] BIT_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_LAST = 4'h9;
    localparam logic [2:0] START_SAMPLES = 3'h7;
    localparam logic [2:0] BIT_SAMPLES = 3'h3;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] BASE_FRAME_BITS = 4'ha;
    localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
    localparam logic [7:0] IDLE_TICKS_8 = 8'ha0;
    localparam logic [7:0] IDLE_TICKS_9 = 8'hb0;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } ucsc_rx_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] ctl_main;
        logic [7:0] frame_ctl;
        logic [4:0] hi_buf;
        logic [12:0] divisor;
        logic two_stop;
        logic long_brk;
        logic t8;
        logic wire_dir;
        logic [12:0] bcnt;
        logic tick;
        logic [7:0] flags;
        logic [7:0] pend;
        logic [8:0] tx_buf;
        logic tx_busy;
        logic [15:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_sub;
        logic pre_pend;
        logic brk_pend;
        logic tx_line;
        logic tx_oe;
        ucsc_rx_t rx_state;
        logic [3:0] rx_sub;
        logic [3:0] rx_bits;
        logic [2:0] rx_ones;
        logic [8:0] rx_shift;
        logic rx_noise;
        logic rx_fe;
        logic [8:0] rx_data;
        logic [7:0] idle_cnt;
        logic idle_armed;
        logic irq;
        logic rx_release;
    } ucsc_state_t;

    localparam ucsc_state_t ST_RST = '{
        rx_state: RX_IDLE,
        flags: STATUS_RST,
        ctl_main: CTL_MAIN_RST,
        divisor: DIV_RST,
        tx_line: 1'b1,
        rx_release: 1'b1,
        default: '0
    };

endpackage : ucsc_pkg

`default_nettype wire

/* File: rtl/ucsc_core.sv */
`timescale 1ns/100ps
`default_nettype none

module ucsc_core
    import ucsc_pkg::*;
#(
    parameter int unsigned ADDR_W = APB_AW
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe,
    output logic rx_pin_release,
    output logic irq
);

    ucsc_state_t st;
    ucsc_state_t next_st;

    logic [2:0] idx;
    logic addr_ok;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic nine;
    logic loop_on;
    logic single_wire;
    logic rx_line;
    logic [3:0] frame_bits;
    logic [8:0] tx_word;
    logic [15:0] tx_frame;
    logic [2:0] n_samp;
    logic [2:0] majority;
    logic bit_v;
    logic noise_now;
    logic fe_now;
    logic [8:0] rx_word;
    logic rx_msb;
    logic [7:0] idle_thr;
    logic tx_active;

    always_comb begin
        next_st = st;
        idx = paddr[4:2];
        addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
        setup = psel && !penable;
        access = psel && penable && st.pready;
        wr = access && pwrite && !st.pslverr;
        rd = access && !pwrite && !st.pslverr;
        nine = st.frame_ctl[FC_NINE];
        loop_on = st.frame_ctl[FC_LOOP];
        single_wire = loop_on && st.frame_ctl[FC_SINGLE];
        frame_bits = 4'(BASE_FRAME_BITS + {3'h0, nine} + {3'h0, st.two_stop});
        idle_thr = nine ? IDLE_TICKS_9 : IDLE_TICKS_8;
        tx_word = st.tx_buf;
        tx_frame = 16'hffff;
        n_samp = BIT_SAMPLES;
        majority = 3'h1;
        bit_v = 1'b0;
        noise_now = 1'b0;
        fe_now = 1'b0;
        rx_word = '0;
        rx_msb = 1'b0;
        // ------------------------------------------------------------
        // Receive source selection.
        // ------------------------------------------------------------
        if (loop_on) begin
            rx_line = st.frame_ctl[FC_SINGLE] ? tx_pin_in : st.tx_line;
        end else begin
            rx_line = rx_pin;
        end

        // ------------------------------------------------------------
        // APB answer: one wait-free access phase after each setup.
        // ------------------------------------------------------------
        next_st.pready = setup;
        next_st.pslverr = setup && !addr_ok;
        if (setup) begin
            next_st.prdata = 32'h0;
            unique case (idx)
                IDX_BAUD_HI: next_st.prdata[7:0] = {2'h0, st.two_stop, st.divisor[12:8]};
                IDX_BAUD_LO: next_st.prdata[7:0] = st.divisor[7:0];
                IDX_FRAME: next_st.prdata[7:0] = st.frame_ctl;
                IDX_CTL_MAIN: next_st.prdata[7:0] = st.ctl_main;
                IDX_STATUS: next_st.prdata[7:0] = st.flags;
                IDX_EXT: next_st.prdata[EX_LONG_BREAK] = st.long_brk;
                IDX_CTL3: next_st.prdata[7:0] = {st.rx_data[8], st.t8, st.wire_dir, 5'h00};
                IDX_DATA: next_st.prdata[7:0] = st.rx_data[7:0];
            endcase
            if (!addr_ok) begin
                next_st.prdata = 32'h0;
            end
        end

        // ------------------------------------------------------------
        // Baud generator: one tick per sixteenth of a bit.
        // ------------------------------------------------------------
        next_st.tick = 1'b0;
        if (st.divisor == '0) begin
            next_st.bcnt = '0;
        end else if (st.bcnt >= 13'(st.divisor - 13'h0001)) begin
            next_st.bcnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.bcnt = 13'(st.bcnt + 13'h0001);
        end

        // ------------------------------------------------------------
        // Transmitter.
        // ------------------------------------------------------------
        if (st.frame_ctl[FC_PE]) begin
            if (nine) begin
                tx_word[8] = ^st.tx_buf[7:0] ^ st.frame_ctl[FC_ODD];
            end else begin
                tx_word[7] = ^st.tx_buf[6:0] ^ st.frame_ctl[FC_ODD];
            end
        end
        tx_frame[0] = 1'b0;
        tx_frame[8:1] = tx_word[7:0];
        if (nine) begin
            tx_frame[9] = tx_word[8];
        end
        if (!st.tx_busy) begin
            next_st.tx_sub = '0;
            if (st.pre_pend) begin
                next_st.tx_busy = 1'b1;
                next_st.tx_shift = 16'hffff;
                next_st.tx_bits = frame_bits;
                next_st.pre_pend = 1'b0;
            end else if (!st.flags[SF_TX_BUFFER_EMPTY]) begin
                next_st.tx_busy = 1'b1;
                next_st.tx_shift = tx_frame;
                next_st.tx_bits = frame_bits;
                next_st.flags[SF_TX_BUFFER_EMPTY] = 1'b1;
            end else if (st.brk_pend) begin
                next_st.tx_busy = 1'b1;
                next_st.tx_shift = 16'h0000;
                next_st.tx_bits = st.long_brk ? 4'(frame_bits + LONG_BREAK_EXTRA) : frame_bits;
                // A break request still held keeps queuing the next one.
                next_st.brk_pend = st.ctl_main[CM_BREAK];
            end
        end else if (st.tick) begin
            next_st.tx_sub = 4'(st.tx_sub + 4'h1);
            if (st.tx_sub == OVS_LAST) begin
                next_st.tx_shift = {1'b1, st.tx_shift[15:1]};
                next_st.tx_bits = 4'(st.tx_bits - 4'h1);
                if (st.tx_bits == 4'h1) begin
                    next_st.tx_busy = 1'b0;
                end
            end
        end

        // ------------------------------------------------------------
        // Register writes and the read side effects.
        // ------------------------------------------------------------
        if (wr) begin
            unique case (idx)
                IDX_BAUD_HI: begin
                    next_st.hi_buf = pwdata[4:0];
                    next_st.two_stop = pwdata[BH_TWO_STOP];
                end
                IDX_BAUD_LO: next_st.divisor = {st.hi_buf, pwdata[7:0]};
                IDX_FRAME: next_st.frame_ctl = pwdata[7:0];
                IDX_CTL_MAIN: begin
                    next_st.ctl_main = pwdata[7:0];
                    if (!st.ctl_main[CM_TE] && pwdata[CM_TE]) begin
                        next_st.pre_pend = 1'b1;
                    end
                    if (pwdata[CM_BREAK]) begin
                        next_st.brk_pend = 1'b1;
                    end
                end
                IDX_STATUS: next_st.flags = st.flags;
                IDX_EXT: next_st.long_brk = pwdata[EX_LONG_BREAK];
                IDX_CTL3: begin
                    next_st.t8 = pwdata[C3_T8];
                    next_st.wire_dir = pwdata[C3_WIRE_DIR];
                end
                IDX_DATA: begin
                    next_st.tx_buf = {st.t8, pwdata[7:0]};
                    if (st.pend[SF_TX_BUFFER_EMPTY]) begin
                        next_st.flags[SF_TX_BUFFER_EMPTY] = 1'b0;
                    end
                    next_st.pend[SF_TX_BUFFER_EMPTY] = 1'b0;
                    next_st.pend[SF_TC] = 1'b0;
                end
            endcase
        end
        if (rd && idx == IDX_STATUS) begin
            next_st.pend = st.prdata[7:0];
        end
        if (rd && idx == IDX_DATA) begin
            // Receive flags clear only if a status read saw them set.
            next_st.flags[SF_RX_BUFFER_FULL:0] = st.flags[SF_RX_BUFFER_FULL:0] & ~st.pend[SF_RX_BUFFER_FULL:0];
            next_st.pend[SF_RX_BUFFER_FULL:0] = '0;
        end

        // ------------------------------------------------------------
        // Receiver: majority vote over the samples of each bit.
        // ------------------------------------------------------------
        if (st.rx_state == RX_START) begin
            n_samp = START_SAMPLES;
            majority = 3'h3;
        end
        bit_v = st.rx_ones > majority;
        noise_now = (st.rx_ones != 3'h0) && (st.rx_ones != n_samp);
        fe_now = st.rx_fe || !bit_v;
        rx_word = nine ? st.rx_shift : {1'b0, st.rx_shift[8:1]};
        rx_msb = nine ? rx_word[8] : rx_word[7];
        if (!st.ctl_main[CM_RE]) begin
            next_st.rx_state = RX_IDLE;
            next_st.rx_ones = '0;
        end else if (st.tick) begin
            unique case (st.rx_state)
                RX_IDLE: begin
                    if (!rx_line) begin
                        next_st.rx_state = RX_START;
                        next_st.rx_sub = 4'h1;
                        next_st.rx_ones = '0;
                    end
                end
                RX_START, RX_DATA, RX_STOP: begin
                    next_st.rx_sub = 4'(st.rx_sub + 4'h1);
                    if (st.rx_sub >= ((st.rx_state == RX_START) ? START_FIRST : BIT_FIRST)
                        && st.rx_sub <= SAMPLE_LAST) begin
                        next_st.rx_ones = 3'(st.rx_ones + {2'h0, rx_line});
                    end
                    if (st.rx_sub == OVS_LAST) begin
                        next_st.rx_ones = '0;
                        next_st.rx_noise = st.rx_noise || noise_now;
                        if (st.rx_state == RX_START) begin
                            next_st.rx_noise = noise_now;
                            next_st.rx_fe = 1'b0;
                            next_st.rx_bits = '0;
                            next_st.rx_state = bit_v ? RX_IDLE : RX_DATA;
                        end else if (st.rx_state == RX_DATA) begin
                            next_st.rx_shift = {bit_v, st.rx_shift[8:1]};
                            next_st.rx_bits = 4'(st.rx_bits + 4'h1);
                            if (st.rx_bits == 4'(DATA_BITS - 4'h1 + {3'h0, nine})) begin
                                next_st.rx_state = RX_STOP;
                                next_st.rx_bits = '0;
                            end
                        end else begin
                            next_st.rx_fe = fe_now;
                            next_st.rx_bits = 4'(st.rx_bits + 4'h1);
                            if (st.rx_bits == {3'h0, st.two_stop}) begin
                                next_st.rx_state = RX_IDLE;
                                if (st.ctl_main[CM_STANDBY]) begin
                                    next_st.idle_armed = 1'b1;
                                end
                                if (st.ctl_main[CM_STANDBY] && st.frame_ctl[FC_WAKE] && rx_msb) begin
                                    next_st.ctl_main[CM_STANDBY] = 1'b0;
                                end
                                if (!st.ctl_main[CM_STANDBY] || (st.frame_ctl[FC_WAKE] && rx_msb)) begin
                                    if (st.flags[SF_RX_BUFFER_FULL]) begin
                                        next_st.flags[SF_OVR] = 1'b1;
                                    end else begin
                                        next_st.rx_data = rx_word;
                                        next_st.flags[SF_RX_BUFFER_FULL] = 1'b1;
                                        next_st.flags[SF_NF] = st.rx_noise || noise_now;
                                        next_st.flags[SF_FE] = fe_now;
                                        next_st.flags[SF_PF] = st.frame_ctl[FC_PE]
                                            && ((^rx_word) != st.frame_ctl[FC_ODD]);
                                        next_st.idle_armed = 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
            endcase
        end

        // ------------------------------------------------------------
        // Idle line detection.
        // ------------------------------------------------------------
        if (!st.ctl_main[CM_RE] || !rx_line
            || (st.frame_ctl[FC_ILT] && st.rx_state != RX_IDLE)) begin
            next_st.idle_cnt = '0;
        end else if (st.tick && st.idle_cnt != idle_thr) begin
            next_st.idle_cnt = 8'(st.idle_cnt + 8'h01);
            if (8'(st.idle_cnt + 8'h01) == idle_thr && st.idle_armed) begin
                // Only one idle event per period; a new character rearms it, unless overrun drops it outside standby.
                next_st.idle_armed = 1'b0;
                if (st.ctl_main[CM_STANDBY]) begin
                    if (!st.frame_ctl[FC_WAKE]) begin
                        next_st.ctl_main[CM_STANDBY] = 1'b0;
                    end
                end else begin
                    next_st.flags[SF_IDLE] = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // Status levels and pin outputs.
        // ------------------------------------------------------------
        next_st.flags[SF_TC] = next_st.flags[SF_TX_BUFFER_EMPTY] && !next_st.tx_busy
            && !next_st.pre_pend && !next_st.brk_pend;
        next_st.tx_line = next_st.tx_busy ? next_st.tx_shift[0] : 1'b1;
        tx_active = next_st.ctl_main[CM_TE] || next_st.tx_busy || next_st.pre_pend
            || next_st.brk_pend || !next_st.flags[SF_TX_BUFFER_EMPTY];
        next_st.tx_oe = tx_active && (!single_wire || next_st.wire_dir);
        next_st.rx_release = !next_st.ctl_main[CM_RE] || next_st.frame_ctl[FC_LOOP];
        next_st.irq = (next_st.flags[SF_TX_BUFFER_EMPTY] && next_st.ctl_main[CM_TX_EMPTY_IE])
            || (next_st.flags[SF_TC] && next_st.ctl_main[CM_TX_DONE_IE])
            || (next_st.flags[SF_RX_BUFFER_FULL] && next_st.ctl_main[CM_RX_FULL_IE])
            || (next_st.flags[SF_IDLE] && next_st.ctl_main[CM_IDLE_IE]);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign tx_pin_out = st.tx_line;
    assign tx_pin_oe = st.tx_oe;
    assign rx_pin_release = st.rx_release;
    assign irq = st.irq;

endmodule : ucsc_core

`default_nettype wire

/* File: verif/ucsc_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module ucsc_sva (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_pin_oe,
    input wire logic rx_pin_release,
    input wire logic irq
);
    logic [7:0] ctl;
    logic [7:0] frm;
    logic setup;
    logic bad;
    logic wr;
    logic rel;
    logic drv;
    assign setup = psel && !penable;
    assign bad = (paddr[1:0] != 2'h0) || (paddr[7:5] != 3'h0);
    assign wr = psel && penable && pready && pwrite;
    assign rel = !ctl[2] || frm[7];
    assign drv = ctl[3] && !(frm[7] && frm[5]);
    // Shadow copies of the control bytes, so pin rules can be checked from the bus alone.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) ctl <= 8'h00;
        else if (wr && paddr == 8'h0c) ctl <= pwdata[7:0];
    end
    always_ff @(posedge sys_clk) begin
        if (!reset_n) frm <= 8'h00;
        else if (wr && paddr == 8'h08) frm <= pwdata[7:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_ready_after_setup: assert property (setup |=> pready) else $error("no answer to setup");
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_bad_addr: assert property (setup && bad |=> pslverr && pready) else $error("bad address taken");
    a_err_good_addr: assert property (setup && !bad |=> !pslverr) else $error("good address refused");
    a_irq_all_masked: assert property ((ctl[7:4] == 4'h0) [*3] |-> !irq) else $error("masked irq");
    a_rx_release_on: assert property (rel [*3] |-> rx_pin_release) else $error("rx pin kept");
    a_rx_release_off: assert property (!rel [*3] |-> !rx_pin_release) else $error("rx pin lost");
    a_tx_pin_driven: assert property (drv [*3] |-> tx_pin_oe) else $error("tx pin not driven");
    c_irq: cover property (irq);
    c_slverr: cover property (pready && pslverr);
    c_tx_drive: cover property (tx_pin_oe);
endmodule : ucsc_sva
`default_nettype wire

/* File: verif/ucsc_remote.sv */
`timescale 1ns/100ps
`default_nettype none
module ucsc_remote #(
    parameter int BIT_CLK = 64
) (
    input wire logic sys_clk,
    input wire logic tx_line,
    output logic rx_line
);
    initial rx_line = 1'b1;
    // Bits go out lsb first: start, eight data, one stop; the line idles high after.
    task automatic send(input logic [9:0] bits);
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            rx_line <= bits[i];
            repeat (BIT_CLK - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        rx_line <= 1'b1;
    endtask : send
    // Samples mid-bit, so a small phase error of the sender does not matter.
    task automatic get(output logic [7:0] d);
        wait (tx_line === 1'b0);
        repeat (BIT_CLK / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLK) @(posedge sys_clk);
            d[i] = tx_line;
        end
    endtask : get
endmodule : ucsc_remote
`default_nettype wire

/* File: verif/uart_control_status_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module uart_control_status_core_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_pin, tx_pin_out, tx_pin_oe, rx_pin_release, irq, tx_wire, err;
    logic [7:0] d;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] fr [3] = '{8'h00, 8'h02, 8'h03};
    logic [7:0] txd [3] = '{8'ha5, 8'h01, 8'h01};
    logic [7:0] txe [3] = '{8'ha5, 8'h81, 8'h01};
    always #25 sys_clk = ~sys_clk;
    // A released transmit wire is pulled up on the board.
    assign tx_wire = tx_pin_oe ? tx_pin_out : 1'b1;
    ucsc_core dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_release(rx_pin_release),
        .irq(irq));
    ucsc_remote #(.BIT_CLK(64)) rem_u (.sys_clk(sys_clk), .tx_line(tx_wire), .rx_line(rx_pin));
    task automatic complete_run();
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        d = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(d, exp);
    endtask : rd
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(8'h10, 8'hc0);
        rd(8'h0c, 8'h00);
        apb(1'b1, 8'h10, 8'h3f);
        rd(8'h10, 8'hc0);
        apb(1'b1, 8'h0c, 8'h08);
        rd(8'h0c, 8'h08);
        // A bad address must be refused on write and read back as zero.
        apb(1'b1, 8'h2c, 8'hff);
        chk({7'h0, err}, 8'h01);
        rd(8'h2c, 8'h00);
        chk({7'h0, err}, 8'h01);
        rd(8'h0c, 8'h08);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 8'h08, fr[k]);
            fork
                rem_u.get(d);
                apb(1'b1, 8'h1c, txd[k]);
            join
            chk(d, txe[k]);
            repeat (128) @(posedge sys_clk);
            rd(8'h10, 8'hc0);
        end
        apb(1'b1, 8'h08, 8'h00);
        apb(1'b1, 8'h0c, 8'h2c);
        rem_u.send({1'b1, 8'h5a, 1'b0});
        for (int i = 0; i < 64 && irq !== 1'b1; i++) @(posedge sys_clk);
        chk({7'h0, irq}, 8'h01);
        rd(8'h1c, 8'h5a);
        rd(8'h10, 8'he0);
        rd(8'h1c, 8'h5a);
        rd(8'h10, 8'hc0);
        chk({7'h0, irq}, 8'h00);
        repeat (800) @(posedge sys_clk);
        rd(8'h10, 8'hd0);
        rd(8'h1c, 8'h5a);
        rd(8'h10, 8'hc0);
        repeat (800) @(posedge sys_clk);
        rd(8'h10, 8'hc0);
        rem_u.send({1'b1, 8'h33, 1'b0});
        rem_u.send({1'b1, 8'h44, 1'b0});
        repeat (64) @(posedge sys_clk);
        rd(8'h10, 8'he8);
        rd(8'h1c, 8'h33);
        rem_u.send({1'b0, 8'h55, 1'b0});
        repeat (64) @(posedge sys_clk);
        rd(8'h10, 8'he2);
        rd(8'h1c, 8'h55);
        // Even parity with a single one below the msb makes the received character wrong.
        apb(1'b1, 8'h08, 8'h02);
        rem_u.send({1'b1, 8'h01, 1'b0});
        repeat (64) @(posedge sys_clk);
        rd(8'h10, 8'he1);
        rd(8'h1c, 8'h01);
        // Internal loopback in nine-bit mode, ninth bit set.
        apb(1'b1, 8'h08, 8'h90);
        apb(1'b1, 8'h18, 8'h40);
        rd(8'h10, 8'hc0);
        apb(1'b1, 8'h1c, 8'h5a);
        repeat (800) @(posedge sys_clk);
        rd(8'h10, 8'he0);
        rd(8'h18, 8'hc0);
        rd(8'h1c, 8'h5a);
        complete_run();
    end
endmodule : uart_control_status_core_tb
bind ucsc_core ucsc_sva chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .tx_pin_oe(tx_pin_oe),
    .rx_pin_release(rx_pin_release), .irq(irq));
`default_nettype wire
